//--- hdl/torch_height_cut_sequencer.sv
// Purpose: cut sequencing and lifter step generation of a torch height controller
// Assumes: all inputs synchronous to clk; inputs already active high
// Notes: arc voltage arrives as a 12-bit sample with a valid strobe
// Functional notes
// - cycle start runs probe, then starts cut
// - voltage hold freezes height correction
// - motion permit after ignition plus pierce delay
// - cutter start contact strikes the arc
// - arc valid watched through whole cut
// - lifter driven by differential step and dir
// - ohmic input detects plate contact
// - excessive voltage slope halts height correction
// - float input also detects plate contact
// - arc valid drop during cut is loss
`timescale 1ns/1ps
`include "thc_seq_defs.svh"
module torch_height_cut_sequencer (
    input wire logic clk,
    input wire logic rst,
    input wire logic cycle_start,
    input wire logic voltage_hold_input,
    input wire logic arc_valid_input,
    input wire logic ohmic_contact,
    input wire logic float_contact,
    input wire logic [11:0] arc_volts,
    input wire logic arc_volts_valid,
    input wire logic [11:0] volts_setpoint,
    output thc_seq_pkg::motor_pins_t motor,
    output logic cutter_start,
    output logic motion_permit,
    output logic arc_lost,
    output logic regulating
);
    thc_seq_pkg::seq_state_t state;
    thc_seq_pkg::seq_state_t next_state;
    logic [31:0] timer;
    logic [15:0] lift_count;
    logic [15:0] half_count;
    logic step_level;
    logic dir_up;
    logic [11:0] avg_volts;
    logic [11:0] prev_volts;
    logic slope_trip;

    function automatic logic [11:0] abs_diff(input logic [11:0] a, input logic [11:0] b);
        abs_diff = (a > b) ? (a - b) : (b - a);
    endfunction : abs_diff

    // either sensor counts; float kept as crash backup when ohmic fails on dirty plate
    wire surface_hit = ohmic_contact | float_contact;
    wire pierce_done = (timer >= 32'(`PIERCE_DELAY_CYC - 1));
    wire ignite_late = (timer >= 32'(`IGNITE_TIMEOUT_CYC - 1));
    wire half_tick = (half_count == 16'(`STEP_HALF_CYC - 1));
    wire slope_now = arc_volts_valid && (abs_diff(arc_volts, prev_volts) > `SLOPE_LIMIT);
    wire in_arc = (state == thc_seq_pkg::st_pierce) || (state == thc_seq_pkg::st_cut);
    wire arc_drop = in_arc && !arc_valid_input;
    // correction only in cut, not held, not tripped by a void
    wire reg_enable = (state == thc_seq_pkg::st_cut) && !voltage_hold_input && !slope_trip;
    wire too_high = abs_diff(avg_volts, volts_setpoint) > `VOLT_DEADBAND && avg_volts > volts_setpoint;
    wire too_low = abs_diff(avg_volts, volts_setpoint) > `VOLT_DEADBAND && avg_volts < volts_setpoint;
    wire probe_move = (state == thc_seq_pkg::st_probe_down) || (state == thc_seq_pkg::st_probe_lift);
    wire want_step = probe_move || (reg_enable && (too_high || too_low));
    // high arc voltage means a long arc, so the torch goes down; low voltage lifts it
    wire want_up = (state == thc_seq_pkg::st_probe_lift) || (reg_enable && too_low);
    wire step_fall = half_tick && step_level;
    wire lift_done = (lift_count == `PROBE_LIFT_STEPS);
    // outputs follow the next state so contacts open on the very edge the state leaves
    wire next_cutter = (next_state == thc_seq_pkg::st_ignite) || (next_state == thc_seq_pkg::st_pierce)
        || (next_state == thc_seq_pkg::st_cut);
    wire next_permit = (next_state == thc_seq_pkg::st_cut);
    wire next_lost = (next_state == thc_seq_pkg::st_arc_lost);
    wire next_regulating = (next_state == thc_seq_pkg::st_cut) && reg_enable;

    // dropping cycle_start ends any cycle; a lost arc stays flagged until that drop
    always_comb begin
        next_state = state;
        case (state)
            thc_seq_pkg::st_idle: begin
                if (cycle_start) begin
                    next_state = thc_seq_pkg::st_probe_down;
                end
            end
            thc_seq_pkg::st_probe_down: begin
                if (surface_hit) begin
                    next_state = thc_seq_pkg::st_probe_lift;
                end
            end
            thc_seq_pkg::st_probe_lift: begin
                if (lift_done) begin
                    next_state = thc_seq_pkg::st_ignite;
                end
            end
            thc_seq_pkg::st_ignite: begin
                if (arc_valid_input) begin
                    next_state = thc_seq_pkg::st_pierce;
                end else if (ignite_late) begin
                    next_state = thc_seq_pkg::st_arc_lost;
                end
            end
            thc_seq_pkg::st_pierce: begin
                if (arc_drop) begin
                    next_state = thc_seq_pkg::st_arc_lost;
                end else if (pierce_done) begin
                    next_state = thc_seq_pkg::st_cut;
                end
            end
            thc_seq_pkg::st_cut: begin
                if (arc_drop) begin
                    next_state = thc_seq_pkg::st_arc_lost;
                end
            end
            thc_seq_pkg::st_arc_lost: begin
                next_state = thc_seq_pkg::st_arc_lost;
            end
            default: begin
                next_state = thc_seq_pkg::st_idle;
            end
        endcase
        if (!cycle_start) begin
            next_state = thc_seq_pkg::st_idle;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= thc_seq_pkg::st_idle;
        end else begin
            state <= next_state;
        end
    end

    // restarts on every state change, so each wait is timed from its own entry
    always_ff @(posedge clk) begin
        if (rst || next_state != state) begin
            timer <= 32'h0;
        end else begin
            timer <= timer + 32'h1;
        end
    end

    // step generator: each step is one high and one low half period
    always_ff @(posedge clk) begin
        if (rst || (!want_step && !step_level) || half_tick) begin
            half_count <= 16'h0;
        end else begin
            half_count <= half_count + 16'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            step_level <= 1'b0;
            dir_up <= 1'b0;
        end else if (half_tick) begin
            step_level <= !step_level && want_step;
        end else if (!step_level) begin
            dir_up <= want_up; // dir only changes between pulses, keeps driver setup time
        end
    end

    always_ff @(posedge clk) begin
        if (rst || state != thc_seq_pkg::st_probe_lift) begin
            lift_count <= 16'h0;
        end else if (step_fall && dir_up) begin
            // only up pulses count; the touching down pulse also ends in this state
            lift_count <= lift_count + 16'h1;
        end
    end

    // moving average against fast slope; trip latched until next cut
    always_ff @(posedge clk) begin
        if (rst) begin
            avg_volts <= 12'h000;
            prev_volts <= 12'h000;
            slope_trip <= 1'b0;
        end else begin
            if (arc_volts_valid) begin
                prev_volts <= arc_volts;
                avg_volts <= avg_volts - (avg_volts >> `AVG_SHIFT) + (arc_volts >> `AVG_SHIFT);
            end
            if (state != thc_seq_pkg::st_cut) slope_trip <= 1'b0;
            else if (slope_now) slope_trip <= 1'b1;
        end
    end

    // inverted legs idle high so the pairs stay complementary in reset too
    always_ff @(posedge clk) begin
        if (rst) begin
            motor.step_p <= 1'b0;
            motor.step_n <= 1'b1;
            motor.dir_p <= 1'b0;
            motor.dir_n <= 1'b1;
        end else begin
            motor.step_p <= step_level;
            motor.step_n <= !step_level;
            motor.dir_p <= dir_up;
            motor.dir_n <= !dir_up;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cutter_start <= 1'b0;
            motion_permit <= 1'b0;
        end else begin
            cutter_start <= next_cutter;
            motion_permit <= next_permit;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            arc_lost <= 1'b0;
            regulating <= 1'b0;
        end else begin
            arc_lost <= next_lost;
            regulating <= next_regulating;
        end
    end
endmodule : torch_height_cut_sequencer

//--- hdl/thc_seq_defs.svh
// Purpose: constants for the torch height cut sequencer
// Assumes: 100 MHz clock
// Notes: times in their own unit, cycle counts derived from them; pierce and step times kept short, raise for a real lifter
`ifndef THC_SEQ_DEFS_SVH
`define THC_SEQ_DEFS_SVH
`define CLK_MHZ 100
`define PIERCE_DELAY_US 100
`define PIERCE_DELAY_CYC (`PIERCE_DELAY_US * `CLK_MHZ)
`define IGNITE_TIMEOUT_US 5000
`define IGNITE_TIMEOUT_CYC (`IGNITE_TIMEOUT_US * `CLK_MHZ)
`define STEP_HALF_US 1
`define STEP_HALF_CYC (`STEP_HALF_US * `CLK_MHZ)
`define PROBE_LIFT_STEPS 16'h0020
`define VOLT_DEADBAND 12'h010
`define SLOPE_LIMIT 12'h040
`define AVG_SHIFT 3
`endif

//--- hdl/thc_seq_pkg.sv
// Purpose: types for the torch height cut sequencer
// Assumes: nothing
// Notes: state enum and grouped pins
package thc_seq_pkg;
    typedef enum logic [2:0] {
        st_idle, st_probe_down, st_probe_lift, st_ignite, st_pierce, st_cut, st_arc_lost
    } seq_state_t;
    typedef struct packed {
        logic step_p;
        logic step_n;
        logic dir_p;
        logic dir_n;
    } motor_pins_t;
endpackage : thc_seq_pkg

//--- tb/thc_checker.sv
// Purpose: port checks of the cut sequencer
// Assumes: one clock, synchronous rst
// Notes: bound after endmodule
`timescale 1ns/1ps
module thc_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic voltage_hold_input,
    input wire logic arc_valid_input,
    input thc_seq_pkg::motor_pins_t motor,
    input wire logic cutter_start,
    input wire logic motion_permit,
    input wire logic arc_lost
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence arc_gone; motion_permit && !arc_valid_input; endsequence
    sequence contacts_open; !cutter_start && !motion_permit && arc_lost; endsequence
    AST_STEP_PAIR: assert property (motor.step_n != motor.step_p) else $error("step pair");
    AST_DIR_PAIR: assert property (motor.dir_n != motor.dir_p) else $error("dir pair");
    AST_STEP_WIDTH: assert property ($rose(motor.step_p) |-> motor.step_p [*8]) else $error("short step");
    AST_CUT_AFTER_LIFT: assert property ($rose(cutter_start) |-> motor.dir_p) else $error("early start");
    AST_PERMIT_ARC: assert property (motion_permit |-> cutter_start && $past(arc_valid_input)) else $error("permit");
    AST_PERMIT_LATE: assert property ($rose(motion_permit) |-> $past(arc_valid_input, 200)) else $error("early");
    AST_ARC_LOSS: assert property (arc_gone |=> contacts_open) else $error("arc loss");
    AST_HOLD_FREEZE: assert property ((motion_permit && voltage_hold_input) [*3] |-> !$rose(motor.step_p))
        else $error("step in hold");
endmodule : thc_checker
bind torch_height_cut_sequencer thc_checker thc_checker_inst (.clk(clk), .rst(rst), .motor(motor),
    .voltage_hold_input(voltage_hold_input), .arc_valid_input(arc_valid_input), .cutter_start(cutter_start),
    .motion_permit(motion_permit), .arc_lost(arc_lost));

//--- tb/thc_far_side.sv
// Purpose: plate, plasma source stand-in
// Assumes: torch meets the plate on its first down step
// Notes: arc answers 20 cycles after the start contact
`timescale 1ns/1ps
module thc_far_side (
    input wire logic clk,
    input thc_seq_pkg::motor_pins_t motor,
    input wire logic cutter_start,
    input wire logic [1:0] touch_sel,
    input wire logic kill_arc,
    output logic ohmic_contact,
    output logic float_contact,
    output logic arc_valid_input
);
    logic at_plate = 1'b0;
    logic [7:0] arc_cnt = 8'h00;
    assign ohmic_contact = at_plate & touch_sel[0];
    assign float_contact = at_plate & touch_sel[1];
    assign arc_valid_input = (arc_cnt >= 8'h14);
    always @(posedge clk) begin
        at_plate <= motor.dir_p ? 1'b0 : (at_plate | motor.step_p);
        arc_cnt <= (!cutter_start || kill_arc) ? 8'h00 : arc_cnt + {7'h00, arc_cnt != 8'hff};
    end
endmodule : thc_far_side

//--- tb/tb.sv
// Purpose: self-checking bench of the cut sequencer
// Assumes: the shortened timing constants of the defs header
// Notes: rows cover the probe sensors, then one whole cut
`timescale 1ns/1ps
`include "thc_seq_defs.svh"
module tb;
    logic clk = 1'b0, rst = 1'b1, cycle_start = 1'b0, hold = 1'b0, vvalid = 1'b0, kill_arc = 1'b0, prev = 1'b0;
    logic ohmic, flt, arc, cs, mp, lost, reg_on;
    logic [1:0] touch_sel = 2'h1;
    logic [2:0] rows [4] = '{3'h0, 3'h3, 3'h5, 3'h7};
    thc_seq_pkg::motor_pins_t motor;
    int ups = 0, downs = 0, failures = 0, samples_checked = 0, n, base;
    always #5 clk = ~clk;
    always @(posedge clk) vvalid <= ~vvalid;
    always @(posedge clk) begin
        prev <= motor.step_p;
        if (motor.step_p && !prev) begin
            if (motor.dir_p) ups <= ups + 1;
            else downs <= downs + 1;
        end
    end
    torch_height_cut_sequencer torch_height_cut_sequencer_inst (.clk(clk), .rst(rst), .cycle_start(cycle_start),
        .voltage_hold_input(hold), .arc_valid_input(arc), .ohmic_contact(ohmic), .float_contact(flt),
        .arc_volts(12'h200), .arc_volts_valid(vvalid), .volts_setpoint(12'h100), .motor(motor),
        .cutter_start(cs), .motion_permit(mp), .arc_lost(lost), .regulating(reg_on));
    thc_far_side thc_far_side_inst (.clk(clk), .motor(motor), .cutter_start(cs), .touch_sel(touch_sel),
        .kill_arc(kill_arc), .ohmic_contact(ohmic), .float_contact(flt), .arc_valid_input(arc));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    initial begin
        #400000;
        failures++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({cs, mp, lost, reg_on, motor}, 16'h0005);
        foreach (rows[i]) begin
            touch_sel <= rows[i][2:1];
            cycle_start <= 1'b1;
            for (n = 0; n < 4000 && motor.dir_p !== 1'b1; n++) @(posedge clk);
            check(motor.dir_p, rows[i][0]);
            cycle_start <= 1'b0;
            rst <= 1'b1;
            @(posedge clk);
            rst <= 1'b0;
        end
        touch_sel <= 2'h1;
        cycle_start <= 1'b1;
        for (n = 0; n < 80000 && cs !== 1'b1; n++) @(posedge clk);
        check(ups, 16'h0020);
        for (n = 0; n < `PIERCE_DELAY_CYC + 1000 && mp !== 1'b1; n++) @(posedge clk);
        check(n >= `PIERCE_DELAY_CYC && n < `PIERCE_DELAY_CYC + 100, 16'h0001);
        // cnc freezes height only once motion is permitted, as in a corner
        hold <= 1'b1;
        repeat (4) @(posedge clk);
        base = ups + downs;
        repeat (3000) @(posedge clk);
        check(ups + downs - base, 16'h0000);
        hold <= 1'b0;
        base = downs;
        for (n = 0; n < 5000 && downs == base; n++) @(posedge clk);
        check({reg_on, downs != base}, 16'h0003);
        kill_arc <= 1'b1;
        @(posedge clk);
        kill_arc <= 1'b0;
        repeat (2) @(posedge clk);
        check({cs, mp, lost, reg_on}, 16'h0002);
        repeat (20) @(posedge clk);
        check(lost, 16'h0001);
        cycle_start <= 1'b0;
        repeat (3) @(posedge clk);
        check(lost, 16'h0000);
        end_of_test();
    end
endmodule : tb
